// >>> rtl/sercfg_pkg.sv
// constants and types for the serializer control block
package sercfg_pkg;
  localparam int IDX_W = 8;
  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PWR = 8'h01;
  localparam logic [IDX_W-1:0] IDX_CTRL = 8'h03;
  localparam logic [IDX_W-1:0] IDX_MODE = 8'h04;
  localparam logic [IDX_W-1:0] IDX_LINK = 8'h0C;
  localparam logic [IDX_W-1:0] IDX_CFG = 8'h12;
  localparam logic [IDX_W-1:0] IDX_INTCTL = 8'hC6;
  localparam logic [IDX_W-1:0] IDX_ISR = 8'hC7;
  // field positions
  localparam int PWR_APD_EN_BIT = 7;
  localparam int CTRL_FILT_EN_BIT = 0;
  localparam int CTRL_EDGE_BIT = 1;
  localparam int CTRL_SLEEP_EN_BIT = 2;
  localparam int CFG_AUDB_BIT = 0;
  localparam int CFG_BC_BIT = 1;
  localparam int CFG_REP_BIT = 2;
  localparam int CFG_USE_REG_BIT = 7;
  localparam int INT_ARM_HI_BIT = 5;
  localparam int INT_ARM_LO_BIT = 0;
  // reset values
  localparam logic [7:0] PWR_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h03;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] INTCTL_RST = 8'h00;
  // filter counts in pixel clocks
  localparam int WINDOW_CYC = 130;
  localparam int MIN_PULSE_CYC = 3;
  // strap levels
  localparam logic [3:0] STRAP_BC_LO = 4'h9;
  localparam logic [3:0] STRAP_BC_HI = 4'hA;
  // pixel clock range limits in MHz
  localparam logic [6:0] PCLK_LF_MIN = 7'h05;
  localparam logic [6:0] PCLK_HF_MIN = 7'h0F;
  localparam logic [6:0] PCLK_LF_MAX = 7'h0F;
  localparam logic [6:0] PCLK_HF_MAX = 7'h55;
  localparam logic [6:0] PCLK_BC_MAX = 7'h41;
  typedef enum {ST_OFF, ST_NORMAL, ST_REMOTE_PD, ST_SLEEP} power_state_e;
endpackage

// >>> rtl/serializer_control_and_mode_select.sv
// serializer control: control filter, power states, faults, interrupt, strap, ahb registers
//
// Implementation choices: the AHB-Lite slave port and the register addresses.
module serializer_control_and_mode_select #(
  parameter int DATA_W = 24
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // video inputs
  input wire logic i_active_video_in,
  input wire logic i_line_sync_in,
  input wire logic i_frame_sync_in,
  input wire logic [DATA_W-1:0] i_pixel_data,
  // video toward the serial link
  output logic o_active_video,
  output logic o_line_sync,
  output logic o_frame_sync,
  output logic [DATA_W-1:0] o_pixel_data,
  // power and link status
  input wire logic i_power_down_n_in,
  input wire logic i_remote_powered_down,
  input wire logic i_pclk_lost,
  input wire logic i_cable_fault,
  output logic o_link_enable,
  output logic o_remote_pd,
  output logic o_sleep,
  // interrupt
  input wire logic i_remote_interrupt_in_n,
  output logic o_interrupt_out_n,
  // configuration strap and mode outputs
  input wire logic [3:0] i_mode_sel_level,
  output logic o_low_freq_range_mode,
  output logic o_repeater,
  output logic o_backward_compat,
  output logic o_second_audio,
  output logic [6:0] o_pclk_min_mhz,
  output logic [6:0] o_pclk_max_mhz
);
  import sercfg_pkg::*;

  logic [7:0] pwr_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] mode_reg;
  logic [7:0] cfg_reg;
  logic [7:0] intctl_reg;
  logic link_detect;
  logic int_pending;
  logic wr_pend;
  logic [IDX_W-1:0] wr_idx;
  logic [31:0] next_rdata;
  logic rd_take;
  logic isr_rd;
  power_state_e state;
  power_state_e next_state;

  // ahb address phase
  logic addr_take;
  logic [IDX_W-1:0] a_idx;
  assign addr_take = i_hsel && i_htrans[1] && i_hready;
  assign a_idx = i_haddr[IDX_W+1:2];
  assign rd_take = addr_take && !i_hwrite;
  assign isr_rd = rd_take && (a_idx == IDX_ISR);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_pend <= 1'b0;
      wr_idx <= '0;
    end else begin
      wr_pend <= addr_take && i_hwrite;
      wr_idx <= a_idx;
    end
  end

  // data phase writes; no clear on clock loss or sleep
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pwr_reg <= PWR_RST;
      ctrl_reg <= CTRL_RST;
      mode_reg <= MODE_RST;
      cfg_reg <= CFG_RST;
      intctl_reg <= INTCTL_RST;
    end else if (wr_pend) begin
      case (wr_idx)
        IDX_PWR: pwr_reg <= i_hwdata[7:0];
        IDX_CTRL: ctrl_reg <= i_hwdata[7:0];
        IDX_MODE: mode_reg <= i_hwdata[7:0];
        IDX_CFG: cfg_reg <= i_hwdata[7:0];
        IDX_INTCTL: intctl_reg <= i_hwdata[7:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (a_idx)
      IDX_PWR: next_rdata[7:0] = pwr_reg;
      IDX_CTRL: next_rdata[7:0] = ctrl_reg;
      IDX_MODE: next_rdata[7:0] = mode_reg;
      IDX_CFG: next_rdata[7:0] = cfg_reg;
      IDX_INTCTL: next_rdata[7:0] = intctl_reg;
      IDX_LINK: next_rdata[0] = link_detect;
      IDX_ISR: next_rdata[0] = int_pending;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_hrdata <= 32'h0000_0000;
      o_hreadyout <= 1'b0;
      o_hresp <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      if (rd_take) begin
        o_hrdata <= next_rdata;
      end
    end
  end

  // input capture on both edges, one chosen by edge select
  logic [DATA_W+2:0] cap_rise;
  logic [DATA_W+2:0] cap_fall;
  logic [DATA_W+2:0] cap_sel;
  always_ff @(posedge i_clk) begin
    cap_rise <= {i_frame_sync_in, i_line_sync_in, i_active_video_in, i_pixel_data};
  end
  always_ff @(negedge i_clk) begin
    cap_fall <= {i_frame_sync_in, i_line_sync_in, i_active_video_in, i_pixel_data};
  end
  assign cap_sel = ctrl_reg[CTRL_EDGE_BIT] ? cap_rise : cap_fall;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pixel_data <= '0;
      o_frame_sync <= 1'b0;
    end else begin
      o_pixel_data <= cap_sel[DATA_W-1:0];
      o_frame_sync <= cap_sel[DATA_W+2];
    end
  end

  // control filter for active video and line sync
  logic [1:0] filt_in;
  logic [1:0] filt_out;
  logic filt_en;
  assign filt_in = cap_sel[DATA_W+1:DATA_W];
  assign filt_en = ctrl_reg[CTRL_FILT_EN_BIT];
  assign o_active_video = filt_out[0];
  assign o_line_sync = filt_out[1];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_filt
      logic [7:0] age_a;
      logic [7:0] age_b;
      logic [1:0] stab;
      logic need_ok;
      logic accept;
      // pulse must persist before it is forwarded
      assign need_ok = filt_en ? (stab >= 2'(MIN_PULSE_CYC - 1)) : 1'b1;
      assign accept = (filt_in[g] != filt_out[g]) && need_ok
                      && (age_b >= 8'(WINDOW_CYC));
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          stab <= 2'h0;
        end else if (filt_in[g] == filt_out[g] || accept) begin
          stab <= 2'h0;
        end else if (stab != 2'h3) begin
          stab <= stab + 2'h1;
        end
      end
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          age_a <= 8'(WINDOW_CYC);
          age_b <= 8'(WINDOW_CYC);
        end else if (accept) begin
          age_b <= (age_a >= 8'(WINDOW_CYC)) ? 8'(WINDOW_CYC) : age_a + 8'h01;
          age_a <= 8'h01;
        end else begin
          if (age_a < 8'(WINDOW_CYC)) begin
            age_a <= age_a + 8'h01;
          end
          if (age_b < 8'(WINDOW_CYC)) begin
            age_b <= age_b + 8'h01;
          end
        end
      end
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          filt_out[g] <= 1'b0;
        end else if (accept) begin
          filt_out[g] <= filt_in[g];
        end
      end
      chk_rate_window: assert property (@(posedge i_clk) disable iff (i_rst)
        $changed(filt_out[g]) |-> $past(age_b) >= 8'(WINDOW_CYC))
        else $error("control edge forwarded inside rate window");
      chk_min_pulse: assert property (@(posedge i_clk) disable iff (i_rst)
        filt_en && $past(filt_en) && $changed(filt_out[g])
        |-> $past(filt_in[g], 1) == filt_out[g] && $past(filt_in[g], 2) == filt_out[g]
            && $past(filt_in[g], 3) == filt_out[g])
        else $error("short control pulse forwarded");
    end
  endgenerate

  // power state machine
  logic apd_en;
  logic sleep_en;
  assign apd_en = pwr_reg[PWR_APD_EN_BIT];
  assign sleep_en = ctrl_reg[CTRL_SLEEP_EN_BIT];

  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: next_state = ST_NORMAL;
      ST_NORMAL: begin
        if (sleep_en && i_pclk_lost) begin
          next_state = ST_SLEEP;
        end else if (apd_en && i_remote_powered_down) begin
          next_state = ST_REMOTE_PD;
        end
      end
      ST_REMOTE_PD: begin
        if (!apd_en || !i_remote_powered_down) begin
          next_state = ST_NORMAL;
        end
      end
      ST_SLEEP: begin
        if (!i_pclk_lost) begin
          next_state = ST_NORMAL;
        end
      end
      default: next_state = ST_OFF;
    endcase
    if (!i_power_down_n_in) begin
      next_state = ST_OFF;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= ST_OFF;
      o_link_enable <= 1'b0;
      o_remote_pd <= 1'b0;
      o_sleep <= 1'b0;
    end else begin
      state <= next_state;
      o_link_enable <= (next_state == ST_NORMAL);
      o_remote_pd <= (next_state == ST_REMOTE_PD);
      o_sleep <= (next_state == ST_SLEEP);
    end
  end

  chk_pdn_link: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_power_down_n_in |=> !o_link_enable && state == ST_OFF)
    else $error("link enabled while power-down held");
  chk_remote_enter: assert property (@(posedge i_clk) disable iff (i_rst)
    state == ST_NORMAL && i_power_down_n_in && apd_en && i_remote_powered_down
    && !(sleep_en && i_pclk_lost) |=> o_remote_pd)
    else $error("remote power-down not entered");
  chk_remote_wake: assert property (@(posedge i_clk) disable iff (i_rst)
    state == ST_REMOTE_PD && i_power_down_n_in && !i_remote_powered_down
    |=> o_link_enable)
    else $error("no return from remote power-down");
  chk_apd_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    !apd_en ##1 !apd_en |-> state != ST_REMOTE_PD)
    else $error("remote power-down while disabled");
  chk_sleep_enter: assert property (@(posedge i_clk) disable iff (i_rst)
    state == ST_NORMAL && i_power_down_n_in && sleep_en && i_pclk_lost
    |=> o_sleep ##1 (o_sleep || !$past(i_power_down_n_in) || !$past(i_pclk_lost)))
    else $error("sleep not entered on clock loss");
  chk_sleep_exit: assert property (@(posedge i_clk) disable iff (i_rst)
    state == ST_SLEEP && i_power_down_n_in && !i_pclk_lost |=> o_link_enable)
    else $error("sleep not left after clock return");
  chk_regs_kept: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_SLEEP || i_pclk_lost) && !wr_pend
    |=> $stable(pwr_reg) && $stable(ctrl_reg) && $stable(cfg_reg) && $stable(mode_reg))
    else $error("register changed during clock loss");

  // link detect status
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      link_detect <= 1'b0;
    end else begin
      link_detect <= !i_cable_fault;
    end
  end
  chk_link_fault: assert property (@(posedge i_clk) disable iff (i_rst)
    i_cable_fault |=> !link_detect)
    else $error("link detect set during cable fault");

  // interrupt forwarding
  logic remote_int_q;
  logic int_fall;
  logic int_armed;
  assign int_armed = intctl_reg[INT_ARM_HI_BIT] && intctl_reg[INT_ARM_LO_BIT];
  assign int_fall = remote_int_q && !i_remote_interrupt_in_n;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      remote_int_q <= 1'b1;
      int_pending <= 1'b0;
      o_interrupt_out_n <= 1'b1;
    end else begin
      remote_int_q <= i_remote_interrupt_in_n;
      // a new edge wins over a clearing read
      if (int_armed && int_fall) begin
        int_pending <= 1'b1;
        o_interrupt_out_n <= 1'b0;
      end else if (isr_rd) begin
        int_pending <= 1'b0;
        o_interrupt_out_n <= 1'b1;
      end
    end
  end
  chk_int_assert: assert property (@(posedge i_clk) disable iff (i_rst)
    int_armed && int_fall |=> !o_interrupt_out_n)
    else $error("interrupt output not asserted");
  chk_int_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    isr_rd && !(int_armed && int_fall) |=> o_interrupt_out_n ##1 (o_interrupt_out_n
    || $past(int_armed && int_fall)))
    else $error("status read did not release interrupt");

  // strap capture at power-down release
  logic pdn_q;
  logic strap_lf;
  logic strap_rep;
  logic strap_bc;
  logic strap_aud;
  logic [3:0] strap_v;
  assign strap_v = i_mode_sel_level - 4'h1;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pdn_q <= 1'b0;
      strap_lf <= 1'b0;
      strap_rep <= 1'b0;
      strap_bc <= 1'b0;
      strap_aud <= 1'b0;
    end else begin
      pdn_q <= i_power_down_n_in;
      if (i_power_down_n_in && !pdn_q) begin
        strap_lf <= 1'b0;
        strap_rep <= 1'b0;
        strap_bc <= 1'b0;
        strap_aud <= 1'b0;
        if (i_mode_sel_level >= 4'h1 && i_mode_sel_level <= 4'h8) begin
          strap_lf <= strap_v[2];
          strap_rep <= strap_v[1];
          strap_aud <= strap_v[0];
        end else if (i_mode_sel_level == STRAP_BC_LO) begin
          strap_bc <= 1'b1;
        end else if (i_mode_sel_level == STRAP_BC_HI) begin
          strap_bc <= 1'b1;
          strap_lf <= 1'b1;
        end
      end
    end
  end

  // configuration source and clock range
  logic use_reg;
  logic cfg_lf;
  logic cfg_bc;
  assign use_reg = cfg_reg[CFG_USE_REG_BIT];
  assign cfg_lf = use_reg ? (mode_reg[1:0] != 2'h0) : strap_lf;
  assign cfg_bc = use_reg ? cfg_reg[CFG_BC_BIT] : strap_bc;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_low_freq_range_mode <= 1'b0;
      o_repeater <= 1'b0;
      o_backward_compat <= 1'b0;
      o_second_audio <= 1'b0;
      o_pclk_min_mhz <= PCLK_HF_MIN;
      o_pclk_max_mhz <= PCLK_HF_MAX;
    end else begin
      o_low_freq_range_mode <= cfg_lf;
      o_repeater <= use_reg ? cfg_reg[CFG_REP_BIT] : strap_rep;
      o_backward_compat <= cfg_bc;
      o_second_audio <= use_reg ? cfg_reg[CFG_AUDB_BIT] : strap_aud;
      o_pclk_min_mhz <= cfg_lf ? PCLK_LF_MIN : PCLK_HF_MIN;
      o_pclk_max_mhz <= cfg_lf ? PCLK_LF_MAX : (cfg_bc ? PCLK_BC_MAX : PCLK_HF_MAX);
    end
  end
  chk_bc_range: assert property (@(posedge i_clk) disable iff (i_rst)
    cfg_bc && !cfg_lf |=> o_pclk_max_mhz == PCLK_BC_MAX && o_pclk_min_mhz == PCLK_HF_MIN)
    else $error("backward mode range wrong");
  chk_strap_bc: assert property (@(posedge i_clk) disable iff (i_rst)
    i_power_down_n_in && !pdn_q && i_mode_sel_level == STRAP_BC_HI
    |=> strap_bc && strap_lf && !strap_rep && !strap_aud)
    else $error("strap level ten decoded wrongly");
endmodule

// >>> sim/remote_deser_model.sv
// model of the paired deserializer: power status and downstream interrupt line
module remote_deser_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // scenario controls
  input wire logic i_pwr_off,
  input wire logic i_src_irq,
  // toward the serializer
  output logic o_powered_down,
  output logic o_interrupt_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // power status follows the commanded state
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_powered_down <= 1'b0;
    end else begin
      o_powered_down <= i_pwr_off;
    end
  end
  // line held low while the scenario source request i_src_irq is high, one clock later
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_interrupt_n <= 1'b1;
    end else begin
      o_interrupt_n <= ~i_src_irq;
    end
  end
endmodule

// >>> sim/serializer_control_and_mode_select_bench.sv
// self-checking bench for the serializer control block
module serializer_control_and_mode_select_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import sercfg_pkg::*;
  typedef struct packed {logic [3:0] level; logic [3:0] cfg;} row_s;
  // cfg packs low-freq, repeater, backward, second audio
  row_s rows [10] = '{'{4'h1, 4'h0}, '{4'h2, 4'h1}, '{4'h3, 4'h4}, '{4'h4, 4'h5},
    '{4'h5, 4'h8}, '{4'h6, 4'h9}, '{4'h7, 4'hC}, '{4'h8, 4'hD}, '{4'h9, 4'h2}, '{4'hA, 4'hA}};
  logic clk, rst, hsel, hwrite, av, ls, fs, pd_n, lost, fault, pwr_off, src_irq;
  logic hrdy, hresp, av_o, ls_o, fs_o, link_en, rpd_o, sleep_o, rpd, rint_n, int_n;
  logic lf, rep, bc, aud;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [23:0] pix, pix_o;
  logic [3:0] level;
  logic [6:0] pmin, pmax;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;

  serializer_control_and_mode_select serializer_control_and_mode_select_i (
    .i_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata), .i_active_video_in(av),
    .i_line_sync_in(ls), .i_frame_sync_in(fs), .i_pixel_data(pix), .o_active_video(av_o),
    .o_line_sync(ls_o), .o_frame_sync(fs_o), .o_pixel_data(pix_o), .i_power_down_n_in(pd_n),
    .i_remote_powered_down(rpd), .i_pclk_lost(lost), .i_cable_fault(fault),
    .o_link_enable(link_en), .o_remote_pd(rpd_o), .o_sleep(sleep_o),
    .i_remote_interrupt_in_n(rint_n), .o_interrupt_out_n(int_n), .i_mode_sel_level(level),
    .o_low_freq_range_mode(lf), .o_repeater(rep), .o_backward_compat(bc),
    .o_second_audio(aud), .o_pclk_min_mhz(pmin), .o_pclk_max_mhz(pmax));

  remote_deser_model remote_deser_model_i (
    .i_clk(clk), .i_rst(rst), .i_pwr_off(pwr_off), .i_src_irq(src_irq),
    .o_powered_down(rpd), .o_interrupt_n(rint_n));

  always #5 clk = ~clk;

  task automatic test_done();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic tick(input int n = 1);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // single word transfer, waits for ready in both phases
  task automatic ahb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'b00};
    tick();
    while (hrdy !== 1'b1) tick();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    tick();
    while (hrdy !== 1'b1) tick();
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    ahb(1'b0, idx, 32'h0);
    check(rd, exp);
    check(32'(hresp), 32'h0);
  endtask

  task automatic pdcycle();
    pd_n <= 1'b0;
    tick(2);
    check(32'(link_en), 32'h0);
    pd_n <= 1'b1;
    tick(3);
    check(32'(link_en), 32'h1);
  endtask

  task automatic chkmode(input logic [3:0] cfg);
    check(32'({lf, rep, bc, aud}), 32'(cfg));
    check(32'(pmin), cfg[3] ? 32'h05 : 32'h0F);
    check(32'(pmax), cfg[3] ? 32'h0F : (cfg[1] ? 32'h41 : 32'h55));
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {hsel, hwrite, av, ls, fs, lost, fault, pwr_off, src_irq} = '0;
    {haddr, hwdata, pix} = '0;
    htrans = 2'b00;
    hsize = 3'h2;
    pd_n = 1'b0;
    level = 4'h1;
    tick(12);
    rst <= 1'b0;
    pd_n <= 1'b1;
    tick(3);
    check(32'(link_en), 32'h1);
    rdchk(IDX_PWR, 32'h0);
    rdchk(IDX_CTRL, 32'h3);
    rdchk(IDX_MODE, 32'h0);
    rdchk(IDX_CFG, 32'h0);
    rdchk(IDX_INTCTL, 32'h0);
    rdchk(8'h55, 32'h0);
    foreach (rows[i]) begin
      level <= rows[i].level;
      pdcycle();
      chkmode(rows[i].cfg);
    end
    ahb(1'b1, IDX_CFG, 32'h87);
    ahb(1'b1, IDX_MODE, 32'h01);
    pdcycle();
    chkmode(4'hF);
    ahb(1'b1, IDX_CFG, 32'h0);
    ahb(1'b1, IDX_MODE, 32'h0);
    pdcycle();
    // filter on: two-cycle glitch dropped
    av <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      tick();
      if (k == 1) av <= 1'b0;
      check(32'(av_o), 32'h0);
    end
    av <= 1'b1;
    tick(3);
    check(32'(av_o), 32'h0);
    tick();
    check(32'(av_o), 32'h1);
    av <= 1'b0;
    tick(4);
    check(32'(av_o), 32'h0);
    av <= 1'b1;
    tick(10);
    check(32'(av_o), 32'h0);
    tick(115);
    check(32'(av_o), 32'h0);
    tick();
    check(32'(av_o), 32'h1);
    // filter off: one-cycle pulse passes, third edge waits
    ahb(1'b1, IDX_CTRL, 32'h02);
    ls <= 1'b1;
    tick();
    ls <= 1'b0;
    tick();
    check(32'(ls_o), 32'h1);
    tick();
    check(32'(ls_o), 32'h0);
    ls <= 1'b1;
    tick(5);
    check(32'(ls_o), 32'h0);
    tick(123);
    check(32'(ls_o), 32'h0);
    tick();
    check(32'(ls_o), 32'h1);
    // capture edge select, rising then falling
    pix <= 24'hA5C31E;
    fs <= 1'b1;
    tick();
    check(32'(pix_o), 32'h0);
    tick();
    check(32'(pix_o), 32'hA5C31E);
    check(32'(fs_o), 32'h1);
    ahb(1'b1, IDX_CTRL, 32'h00);
    pix <= 24'h5A3CE1;
    tick();
    check(32'(pix_o), 32'h5A3CE1);
    // remote power-down, gated then enabled
    pwr_off <= 1'b1;
    tick(4);
    check(32'(rpd_o), 32'h0);
    check(32'(link_en), 32'h1);
    ahb(1'b1, IDX_PWR, 32'h80);
    tick(3);
    check(32'(rpd_o), 32'h1);
    check(32'(link_en), 32'h0);
    pwr_off <= 1'b0;
    tick(4);
    check(32'(rpd_o), 32'h0);
    check(32'(link_en), 32'h1);
    // clock loss sleep, gated then enabled
    lost <= 1'b1;
    tick(3);
    check(32'(sleep_o), 32'h0);
    ahb(1'b1, IDX_CTRL, 32'h04);
    tick(3);
    check(32'(sleep_o), 32'h1);
    rdchk(IDX_CTRL, 32'h04);
    rdchk(IDX_PWR, 32'h80);
    lost <= 1'b0;
    tick(3);
    check(32'(sleep_o), 32'h0);
    check(32'(link_en), 32'h1);
    // cable fault
    fault <= 1'b1;
    tick(2);
    rdchk(IDX_LINK, 32'h0);
    fault <= 1'b0;
    tick(2);
    rdchk(IDX_LINK, 32'h1);
    // interrupt forwarding
    src_irq <= 1'b1;
    tick(4);
    check(32'(int_n), 32'h1);
    src_irq <= 1'b0;
    tick(2);
    ahb(1'b1, IDX_INTCTL, 32'h21);
    src_irq <= 1'b1;
    tick(4);
    check(32'(int_n), 32'h0);
    rdchk(IDX_ISR, 32'h1);
    check(32'(int_n), 32'h1);
    tick(4);
    check(32'(int_n), 32'h1);
    src_irq <= 1'b0;
    tick(3);
    src_irq <= 1'b1;
    tick(4);
    check(32'(int_n), 32'h0);
    rdchk(IDX_ISR, 32'h1);
    check(32'(int_n), 32'h1);
    // mid-run reset brings defaults back
    rst <= 1'b1;
    tick(2);
    check(32'(hrdy), 32'h0);
    check(32'(link_en), 32'h0);
    check(32'(pmax), 32'h55);
    rst <= 1'b0;
    tick(3);
    check(32'(link_en), 32'h1);
    rdchk(IDX_PWR, 32'h0);
    rdchk(IDX_INTCTL, 32'h0);
    test_done();
  end
endmodule
